//--- dual_clock_fifo_mailbox_pkg.sv
// Purpose: Shared constants and carriers for the dual-clock FIFO with mailboxes
// Assumes: 1,024 x 36 build variant; port clocks sampled by the system clock
// Notes:   Offset selector codes and preset offsets are plain defaults
package dual_clock_fifo_mailbox_pkg;

  localparam int DATA_W = 36;
  localparam int ADDR_W = 10;
  localparam int PTR_W  = 11;
  localparam int DEPTH  = 1024;

  localparam logic [PTR_W-1:0]  DEPTH_COUNT = 11'h400;
  localparam logic [PTR_W-1:0]  PTR_RESET   = 11'h000;
  localparam logic [ADDR_W-1:0] OFFSET_RESET       = 10'h000;
  localparam logic [ADDR_W-1:0] PRESET_LOW_OFFSET  = 10'h008;
  localparam logic [ADDR_W-1:0] PRESET_HIGH_OFFSET = 10'h040;
  localparam logic [DATA_W-1:0] DATA_RESET = 36'h0;

  // Serial load: first bit is full-margin MSB, last is empty-margin LSB
  localparam logic [4:0] SERIAL_CNT_RESET = 5'h00;
  localparam logic [4:0] SERIAL_LAST      = 5'h13;

  // Offset method latched from {sel1, sel0} at device reset release
  localparam logic [1:0] SEL_PARALLEL    = 2'h0;
  localparam logic [1:0] SEL_PRESET_LOW  = 2'h1;
  localparam logic [1:0] SEL_PRESET_HIGH = 2'h2;
  localparam logic [1:0] SEL_SERIAL      = 2'h3;

  typedef struct packed {
    logic              clock;
    logic              select_n;
    logic              gate;
    logic              dir;
    logic              mail_select;
    logic [DATA_W-1:0] bus;
  } port_pins_t;

  // Idle pin levels after reset, so no false select or drive appears
  localparam port_pins_t PORT_PINS_IDLE = '{select_n: 1'b1, default: '0};

  typedef struct packed {
    logic serial_bit;
    logic serial_gate;
    logic retransmit_mark_mode;
    logic rewind_to_mark;
    logic device_reset_n;
  } misc_pins_t;

  typedef enum {PROG_IDLE, PROG_PAR_X, PROG_PAR_Y, PROG_SERIAL, PROG_DONE} prog_state_t;

endpackage

//--- dual_clock_fifo_mailbox.sv
// Purpose: Port A to port B FIFO, first word fall through, mailboxes, retransmit
// Assumes: Port clocks far slower than i_clk_sys; all pins pass two flip-flops
// Notes:   Bidirectional buses split into input, output and output enable
`timescale 1ns/1ps
module dual_clock_fifo_mailbox
  import dual_clock_fifo_mailbox_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst_b,
  input  wire logic              i_port_a_clock,
  input  wire logic              i_port_a_select_n,
  input  wire logic              i_port_a_gate,
  input  wire logic              i_port_a_dir,
  input  wire logic              i_port_a_mail_select,
  input  wire logic [DATA_W-1:0] i_port_a_bus,
  output logic      [DATA_W-1:0] o_port_a_bus,
  output logic                   o_port_a_bus_oe,
  input  wire logic              i_port_b_clock,
  input  wire logic              i_port_b_select_n,
  input  wire logic              i_port_b_gate,
  input  wire logic              i_port_b_dir,
  input  wire logic              i_port_b_mail_select,
  input  wire logic [DATA_W-1:0] i_port_b_bus,
  output logic      [DATA_W-1:0] o_port_b_bus,
  output logic                   o_port_b_bus_oe,
  input  wire logic              i_retransmit_mark_mode,
  input  wire logic              i_rewind_to_mark,
  input  wire logic              i_offset_sel0_serial_bit,
  input  wire logic              i_offset_sel1_serial_gate,
  input  wire logic              i_device_reset_n,
  output logic                   o_input_ready,
  output logic                   o_almost_full_n,
  output logic                   o_output_ready,
  output logic                   o_almost_empty_n,
  output logic                   o_mail1_full_n,
  output logic                   o_mail2_full_n
);

  function automatic logic [PTR_W-1:0] ptr_diff(input logic [PTR_W-1:0] a, input logic [PTR_W-1:0] b);
    ptr_diff = a - b;
  endfunction

  function automatic logic [ADDR_W-1:0] addr_of(input logic [PTR_W-1:0] p);
    addr_of = p[ADDR_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  port_pins_t  a_meta, a_sync, b_meta, b_sync;
  misc_pins_t  m_meta, m_sync;
  logic        a_clk_prev, b_clk_prev, dev_rst_n_prev;
  port_pins_t  a_pins, b_pins;
  misc_pins_t  m_pins;

  assign a_pins = '{i_port_a_clock, i_port_a_select_n, i_port_a_gate, i_port_a_dir, i_port_a_mail_select,
                    i_port_a_bus};
  assign b_pins = '{i_port_b_clock, i_port_b_select_n, i_port_b_gate, i_port_b_dir, i_port_b_mail_select,
                    i_port_b_bus};
  assign m_pins = '{i_offset_sel0_serial_bit, i_offset_sel1_serial_gate, i_retransmit_mark_mode,
                    i_rewind_to_mark, i_device_reset_n};

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_meta         <= PORT_PINS_IDLE;
      a_sync         <= PORT_PINS_IDLE;
      b_meta         <= PORT_PINS_IDLE;
      b_sync         <= PORT_PINS_IDLE;
      m_meta         <= '0;
      m_sync         <= '0;
      a_clk_prev     <= 1'b0;
      b_clk_prev     <= 1'b0;
      dev_rst_n_prev <= 1'b0;
    end else begin
      a_meta         <= a_pins;
      a_sync         <= a_meta;
      b_meta         <= b_pins;
      b_sync         <= b_meta;
      m_meta         <= m_pins;
      m_sync         <= m_meta;
      a_clk_prev     <= a_sync.clock;
      b_clk_prev     <= b_sync.clock;
      dev_rst_n_prev <= m_sync.device_reset_n;
    end
  end

  logic dev_rst, dev_release, a_edge, b_edge, a_act, b_act, a_wr, a_rd, b_wr, b_rd;

  always_comb begin
    dev_rst     = ~m_sync.device_reset_n;
    dev_release = m_sync.device_reset_n & ~dev_rst_n_prev;
    a_edge      = a_sync.clock & ~a_clk_prev & ~dev_rst;
    b_edge      = b_sync.clock & ~b_clk_prev & ~dev_rst;
    a_act       = a_edge & ~a_sync.select_n & a_sync.gate;
    b_act       = b_edge & ~b_sync.select_n & b_sync.gate;
    a_wr        = a_act & a_sync.dir;
    a_rd        = a_act & ~a_sync.dir;
    b_wr        = b_act & ~b_sync.dir;
    b_rd        = b_act & b_sync.dir;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State registers and next values
  logic [DATA_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]  wr_ptr, head, mark, next_wr_ptr, next_head, next_mark;
  logic              rt_mode, next_rt_mode;
  logic [DATA_W-1:0] out_data, next_out_data, mail1, next_mail1, mail2, next_mail2;
  logic              ne1, ne2, ae1, ir1, af1, next_ne1, next_ne2, next_ae1, next_ir1, next_af1;
  logic              next_input_ready, next_almost_full_n, next_output_ready, next_almost_empty_n;
  logic              next_mail1_full_n, next_mail2_full_n;
  logic [ADDR_W-1:0] x_off, y_off, next_x_off, next_y_off;
  logic [4:0]        serial_cnt, next_serial_cnt;
  prog_state_t       prog, next_prog;
  logic [DATA_W-1:0] next_port_a_bus, next_port_b_bus;
  logic              next_port_a_bus_oe, next_port_b_bus_oe;
  logic [PTR_W-1:0]  stored, used, free_cnt;
  logic              full, fifo_wr, fifo_rd, rewind, mem_we;
  logic [ADDR_W-1:0] mem_wa;

  always_comb begin
    stored   = ptr_diff(wr_ptr, head);
    used     = ptr_diff(wr_ptr, rt_mode ? mark : head);
    full     = (used == DEPTH_COUNT);
    free_cnt = DEPTH_COUNT - used;
    fifo_wr  = a_wr & ~a_sync.mail_select & o_input_ready & ~full;
    fifo_rd  = b_rd & ~b_sync.mail_select & o_output_ready;
    rewind   = b_edge & rt_mode & m_sync.rewind_to_mark;
    mem_we   = fifo_wr;
    mem_wa   = addr_of(wr_ptr);

    next_wr_ptr         = wr_ptr + PTR_W'(fifo_wr);
    next_head           = head;
    next_mark           = mark;
    next_rt_mode        = rt_mode;
    next_out_data       = out_data;
    next_output_ready   = o_output_ready;
    next_ne1            = ne1;
    next_ne2            = ne2;
    next_ae1            = ae1;
    next_almost_empty_n = o_almost_empty_n;
    next_ir1            = ir1;
    next_input_ready    = o_input_ready;
    next_af1            = af1;
    next_almost_full_n  = o_almost_full_n;
    next_mail1          = mail1;
    next_mail2          = mail2;
    next_mail1_full_n   = o_mail1_full_n;
    next_mail2_full_n   = o_mail2_full_n;
    next_x_off          = x_off;
    next_y_off          = y_off;
    next_serial_cnt     = serial_cnt;
    next_prog           = prog;

    // Retransmit mark and mode
    if (b_edge) begin
      if (!m_sync.retransmit_mark_mode) begin
        next_rt_mode = 1'b0;
      end else if (!rt_mode && o_output_ready) begin
        next_rt_mode = 1'b1;
        next_mark    = head;
      end
    end

    // Output register, first word fall through
    if (rewind) begin
      next_head         = mark;
      next_out_data     = mem[addr_of(mark)];
      next_output_ready = 1'b1;
    end else if (fifo_rd) begin
      next_head = head + PTR_W'(1);
      if (stored > PTR_W'(1)) begin
        next_out_data = mem[addr_of(next_head)];
      end else begin
        next_output_ready = 1'b0;
      end
    end else if (b_edge && ne2 && !o_output_ready && stored != PTR_W'(0)) begin
      next_out_data     = mem[addr_of(head)];
      next_output_ready = 1'b1;
    end

    // Port B status stages
    if (b_edge) begin
      next_ne1            = (stored != PTR_W'(0));
      next_ne2            = ne1;
      next_ae1            = (stored > PTR_W'(x_off));
      next_almost_empty_n = ae1;
    end

    // Port A status stages
    if (a_edge) begin
      next_ir1           = ~full & (prog == PROG_DONE);
      next_input_ready   = ir1;
      next_af1           = (free_cnt > PTR_W'(y_off));
      next_almost_full_n = af1;
    end

    // Mailboxes; a new write wins over a same-cycle read
    if (b_rd && b_sync.mail_select) begin
      next_mail1_full_n = 1'b1;
    end
    if (a_wr && a_sync.mail_select) begin
      next_mail1        = a_sync.bus;
      next_mail1_full_n = 1'b0;
    end
    if (a_rd && a_sync.mail_select) begin
      next_mail2_full_n = 1'b1;
    end
    if (b_wr && b_sync.mail_select) begin
      next_mail2        = b_sync.bus;
      next_mail2_full_n = 1'b0;
    end

    // Margin programming
    case (prog)
      PROG_IDLE: begin
        if (dev_release) begin
          case ({m_sync.serial_gate, m_sync.serial_bit})
            SEL_PRESET_LOW: begin
              next_x_off = PRESET_LOW_OFFSET;
              next_y_off = PRESET_LOW_OFFSET;
              next_prog  = PROG_DONE;
            end
            SEL_PRESET_HIGH: begin
              next_x_off = PRESET_HIGH_OFFSET;
              next_y_off = PRESET_HIGH_OFFSET;
              next_prog  = PROG_DONE;
            end
            SEL_SERIAL: next_prog = PROG_SERIAL;
            default:    next_prog = PROG_PAR_X;
          endcase
        end
      end
      PROG_PAR_X: begin
        if (a_wr && !a_sync.mail_select) begin
          next_x_off = a_sync.bus[ADDR_W-1:0];
          next_prog  = PROG_PAR_Y;
        end
      end
      PROG_PAR_Y: begin
        if (a_wr && !a_sync.mail_select) begin
          next_y_off = a_sync.bus[ADDR_W-1:0];
          next_prog  = PROG_DONE;
        end
      end
      PROG_SERIAL: begin
        if (a_edge && !m_sync.serial_gate) begin
          {next_y_off, next_x_off} = {y_off[ADDR_W-2:0], x_off, m_sync.serial_bit};
          next_serial_cnt = serial_cnt + 5'h01;
          if (serial_cnt == SERIAL_LAST) begin
            next_prog = PROG_DONE;
          end
        end
      end
      PROG_DONE: next_prog = PROG_DONE;
      default:   next_prog = PROG_IDLE;
    endcase

    // Bus drivers
    next_port_a_bus_oe = ~a_sync.select_n & ~a_sync.dir;
    next_port_a_bus    = a_sync.mail_select ? mail2 : DATA_RESET;
    next_port_b_bus_oe = ~b_sync.select_n & b_sync.dir;
    next_port_b_bus    = b_sync.mail_select ? mail1 : out_data;

    // Device reset pin forces pointers, flags and offsets back; mailbox and output data are kept
    if (dev_rst) begin
      next_wr_ptr         = PTR_RESET;
      next_head           = PTR_RESET;
      next_mark           = PTR_RESET;
      next_rt_mode        = 1'b0;
      next_output_ready   = 1'b0;
      next_ne1            = 1'b0;
      next_ne2            = 1'b0;
      next_ae1            = 1'b0;
      next_almost_empty_n = 1'b0;
      next_ir1            = 1'b0;
      next_input_ready    = 1'b0;
      next_af1            = 1'b0;
      next_almost_full_n  = 1'b0;
      next_mail1_full_n   = 1'b1;
      next_mail2_full_n   = 1'b1;
      next_x_off          = OFFSET_RESET;
      next_y_off          = OFFSET_RESET;
      next_serial_cnt     = SERIAL_CNT_RESET;
      next_prog           = PROG_IDLE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (mem_we) begin
      mem[mem_wa] <= a_sync.bus;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr           <= PTR_RESET;
      head             <= PTR_RESET;
      mark             <= PTR_RESET;
      rt_mode          <= 1'b0;
      out_data         <= DATA_RESET;
      o_output_ready   <= 1'b0;
      ne1              <= 1'b0;
      ne2              <= 1'b0;
      ae1              <= 1'b0;
      o_almost_empty_n <= 1'b0;
      ir1              <= 1'b0;
      o_input_ready    <= 1'b0;
      af1              <= 1'b0;
      o_almost_full_n  <= 1'b0;
      mail1            <= DATA_RESET;
      mail2            <= DATA_RESET;
      o_mail1_full_n   <= 1'b1;
      o_mail2_full_n   <= 1'b1;
      x_off            <= OFFSET_RESET;
      y_off            <= OFFSET_RESET;
      serial_cnt       <= SERIAL_CNT_RESET;
      prog             <= PROG_IDLE;
      o_port_a_bus     <= DATA_RESET;
      o_port_a_bus_oe  <= 1'b0;
      o_port_b_bus     <= DATA_RESET;
      o_port_b_bus_oe  <= 1'b0;
    end else begin
      wr_ptr           <= next_wr_ptr;
      head             <= next_head;
      mark             <= next_mark;
      rt_mode          <= next_rt_mode;
      out_data         <= next_out_data;
      o_output_ready   <= next_output_ready;
      ne1              <= next_ne1;
      ne2              <= next_ne2;
      ae1              <= next_ae1;
      o_almost_empty_n <= next_almost_empty_n;
      ir1              <= next_ir1;
      o_input_ready    <= next_input_ready;
      af1              <= next_af1;
      o_almost_full_n  <= next_almost_full_n;
      mail1            <= next_mail1;
      mail2            <= next_mail2;
      o_mail1_full_n   <= next_mail1_full_n;
      o_mail2_full_n   <= next_mail2_full_n;
      x_off            <= next_x_off;
      y_off            <= next_y_off;
      serial_cnt       <= next_serial_cnt;
      prog             <= next_prog;
      o_port_a_bus     <= next_port_a_bus;
      o_port_a_bus_oe  <= next_port_a_bus_oe;
      o_port_b_bus     <= next_port_b_bus;
      o_port_b_bus_oe  <= next_port_b_bus_oe;
    end
  end

endmodule

//--- dual_clock_fifo_mailbox_assertions.sv
// Purpose: Port-level checks on select, direction, reset and mail flags
// Assumes: Pins pass two flip-flops and a register before outputs move
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
module fifo_rule_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_port_a_select_n,
  input wire logic i_port_a_gate,
  input wire logic i_port_a_dir,
  input wire logic i_port_a_mail_select,
  input wire logic i_port_b_select_n,
  input wire logic i_port_b_gate,
  input wire logic i_port_b_dir,
  input wire logic i_port_b_mail_select,
  input wire logic i_device_reset_n,
  input wire logic o_port_a_bus_oe,
  input wire logic o_port_b_bus_oe,
  input wire logic o_input_ready,
  input wire logic o_output_ready,
  input wire logic o_almost_empty_n,
  input wire logic o_mail1_full_n,
  input wire logic o_mail2_full_n
);
  logic [3:0] a_mail_cnt;
  logic [3:0] b_mail_cnt;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  ////////////////////////////////////////////////////////////////
  // Recent mailbox requests on each port
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      a_mail_cnt <= 4'h0;
      b_mail_cnt <= 4'h0;
    end else begin
      a_mail_cnt <= (!i_port_a_select_n && i_port_a_gate && i_port_a_dir && i_port_a_mail_select) ? 4'ha
                    : a_mail_cnt - {3'h0, a_mail_cnt != 4'h0};
      b_mail_cnt <= (!i_port_b_select_n && i_port_b_gate && i_port_b_dir && i_port_b_mail_select) ? 4'ha
                    : b_mail_cnt - {3'h0, b_mail_cnt != 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////
  sequence dev_reset_held;
    !i_device_reset_n [*6];
  endsequence

  sequence a_off_held;
    i_port_a_select_n [*4];
  endsequence

  AST_A_SEL_OFF: assert property (a_off_held |-> !o_port_a_bus_oe)
    else $error("port a driven while deselected");
  AST_A_DIR_OFF: assert property (i_port_a_dir [*4] |-> !o_port_a_bus_oe)
    else $error("port a driven while writing");
  AST_A_OE_CAUSE: assert property ($rose(o_port_a_bus_oe) |-> $past(!i_port_a_select_n && !i_port_a_dir, 3))
    else $error("port a drivers on without read select");
  AST_B_OFF: assert property ((i_port_b_select_n || !i_port_b_dir) [*4] |-> !o_port_b_bus_oe)
    else $error("port b driven while off");
  AST_DEV_RESET: assert property (dev_reset_held |-> !o_input_ready && !o_output_ready
    && !o_almost_empty_n && o_mail1_full_n && o_mail2_full_n)
    else $error("flags wrong during device reset");
  AST_MAIL1_SET: assert property ($fell(o_mail1_full_n) |-> a_mail_cnt != 4'h0)
    else $error("mail1 flag set without mail write");
  AST_MAIL1_CLR: assert property ($rose(o_mail1_full_n) |-> b_mail_cnt != 4'h0 || !i_device_reset_n)
    else $error("mail1 flag cleared without mail read");
  AST_OR_AE: assert property (!o_output_ready |-> !o_almost_empty_n)
    else $error("almost empty high while empty");
endmodule

bind dual_clock_fifo_mailbox fifo_rule_checker u_chk (.i_clk_sys, .i_rst_b, .i_port_a_select_n, .i_port_a_gate,
  .i_port_a_dir, .i_port_a_mail_select, .i_port_b_select_n, .i_port_b_gate, .i_port_b_dir, .i_port_b_mail_select,
  .i_device_reset_n, .o_port_a_bus_oe, .o_port_b_bus_oe, .o_input_ready, .o_output_ready, .o_almost_empty_n,
  .o_mail1_full_n, .o_mail2_full_n);

//--- port_masters_model.sv
// Purpose: Far-side masters: free-running port clocks and bus resolution
// Assumes: Clocks far slower than the system clock, unrelated in phase
// Notes:   An undriven bus shows a pattern that flips every port cycle
`timescale 1ns/1ps
module port_masters_model
  import dual_clock_fifo_mailbox_pkg::*;
(
  output logic              o_port_a_clock,
  output logic              o_port_b_clock,
  input  wire logic              i_a_oe,
  input  wire logic [DATA_W-1:0] i_a_dut,
  input  wire logic              i_a_drive,
  input  wire logic [DATA_W-1:0] i_a_tb,
  output logic      [DATA_W-1:0] o_a_wire,
  input  wire logic              i_b_oe,
  input  wire logic [DATA_W-1:0] i_b_dut,
  input  wire logic              i_b_drive,
  input  wire logic [DATA_W-1:0] i_b_tb,
  output logic      [DATA_W-1:0] o_b_wire
);
  logic float_a = 1'h0;
  logic float_b = 1'h0;

  ////////////////////////////////////////////////////////////////
  // Independent continuous clocks
  initial o_port_a_clock = 1'h0;
  always #20 o_port_a_clock = ~o_port_a_clock;
  initial begin
    o_port_b_clock = 1'h0;
    #7;
    forever #25 o_port_b_clock = ~o_port_b_clock;
  end

  ////////////////////////////////////////////////////////////////
  always @(posedge o_port_a_clock) float_a <= ~float_a;
  always @(posedge o_port_b_clock) float_b <= ~float_b;
  assign o_a_wire = i_a_oe ? i_a_dut : i_a_drive ? i_a_tb : {DATA_W{float_a}};
  assign o_b_wire = i_b_oe ? i_b_dut : i_b_drive ? i_b_tb : {DATA_W{float_b}};
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the dual-clock FIFO with mailboxes
// Assumes: Preset margin of 64 strapped at device reset release
// Notes:   Port controls change six ns after their own port clock edge
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb;
  import dual_clock_fifo_mailbox_pkg::*;
  localparam int M = int'(PRESET_HIGH_OFFSET);
  logic              clk = 1'h0, rst_b = 1'h0, dev_rst_n = 1'h0;
  logic              a_sel_n = 1'h1, a_gate = 1'h0, a_dir = 1'h1, a_mail = 1'h0;
  logic              b_sel_n = 1'h1, b_gate = 1'h0, b_dir = 1'h0, b_mail = 1'h0;
  logic [DATA_W-1:0] a_data = 36'h0, b_data = 36'h0, a_dout, b_dout, a_wire, b_wire;
  logic              pa_clk, pb_clk, a_oe, b_oe, in_rdy, afull_n, or_rdy, aempty_n, mb1_n, mb2_n;
  logic              mark_mode = 1'h0, rewind_pin = 1'h0;
  int                n_errors = 0, comparisons = 0, cycles = 0;

  always #2.5 clk = ~clk;

  port_masters_model u_far (.o_port_a_clock(pa_clk), .o_port_b_clock(pb_clk), .i_a_oe(a_oe), .i_a_dut(a_dout),
    .i_a_drive(a_dir), .i_a_tb(a_data), .o_a_wire(a_wire), .i_b_oe(b_oe), .i_b_dut(b_dout),
    .i_b_drive(!b_dir), .i_b_tb(b_data), .o_b_wire(b_wire));

  dual_clock_fifo_mailbox dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_port_a_clock(pa_clk),
    .i_port_a_select_n(a_sel_n), .i_port_a_gate(a_gate), .i_port_a_dir(a_dir), .i_port_a_mail_select(a_mail),
    .i_port_a_bus(a_wire), .o_port_a_bus(a_dout), .o_port_a_bus_oe(a_oe), .i_port_b_clock(pb_clk),
    .i_port_b_select_n(b_sel_n), .i_port_b_gate(b_gate), .i_port_b_dir(b_dir), .i_port_b_mail_select(b_mail),
    .i_port_b_bus(b_wire), .o_port_b_bus(b_dout), .o_port_b_bus_oe(b_oe), .i_retransmit_mark_mode(mark_mode),
    .i_rewind_to_mark(rewind_pin), .i_offset_sel0_serial_bit(1'h0), .i_offset_sel1_serial_gate(1'h1),
    .i_device_reset_n(dev_rst_n), .o_input_ready(in_rdy), .o_almost_full_n(afull_n), .o_output_ready(or_rdy),
    .o_almost_empty_n(aempty_n), .o_mail1_full_n(mb1_n), .o_mail2_full_n(mb2_n));

  ////////////////////////////////////////////////////////////////
  // Bus cycles
  task a_op(input logic sn, input logic g, input logic d, input logic m, input logic [DATA_W-1:0] w);
    @(posedge pa_clk);
    #6;
    {a_sel_n, a_gate, a_dir, a_mail, a_data} = {sn, g, d, m, w};
    @(posedge pa_clk);
    #6;
    {a_sel_n, a_gate, a_dir} = 3'h5;
  endtask

  task b_op(input logic sn, input logic g, input logic d, input logic m, input logic [DATA_W-1:0] w);
    @(posedge pb_clk);
    #6;
    {b_sel_n, b_gate, b_dir, b_mail, b_data} = {sn, g, d, m, w};
    @(posedge pb_clk);
    #6;
    {b_sel_n, b_gate, b_dir} = 3'h4;
  endtask

  task b_read(input logic m, input logic [DATA_W-1:0] exp);
    @(posedge pb_clk);
    #6;
    {b_sel_n, b_dir, b_mail} = {2'h1, m};
    repeat (2) @(posedge pb_clk);
    `CHK("port_b_bus", exp, b_wire)
    b_op(1'h0, 1'h1, 1'h1, m, 36'h0);
  endtask

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task reset_check();
    int i;
    repeat (6) @(posedge clk);
    #1 rst_b = 1'h1;
    repeat (5) @(posedge pb_clk);
    `CHK("input_ready", 1'h0, in_rdy)
    `CHK("output_ready", 1'h0, or_rdy)
    `CHK("mail1_full_n", 1'h1, mb1_n)
    #1 dev_rst_n = 1'h1;
    for (i = 0; i < 20 && in_rdy !== 1'h1; i++) @(posedge pa_clk);
    `CHK("input_ready", 1'h1, in_rdy)
  endtask

  task refuse_check();
    a_op(1'h1, 1'h1, 1'h1, 1'h0, 36'h1);
    a_op(1'h0, 1'h0, 1'h1, 1'h0, 36'h2);
    repeat (6) @(posedge pb_clk);
    `CHK("output_ready", 1'h0, or_rdy)
  endtask

  task mail_check();
    a_op(1'h0, 1'h1, 1'h1, 1'h1, 36'h9_a5a5_0f0f);
    repeat (4) @(posedge pb_clk);
    `CHK("mail1_full_n", 1'h0, mb1_n)
    b_read(1'h1, 36'h9_a5a5_0f0f);
    repeat (2) @(posedge pb_clk);
    `CHK("mail1_full_n", 1'h1, mb1_n)
    b_op(1'h0, 1'h1, 1'h0, 1'h1, 36'h6_3c3c_f0f0);
    repeat (4) @(posedge pa_clk);
    `CHK("mail2_full_n", 1'h0, mb2_n)
    #6 {a_sel_n, a_dir, a_mail} = 3'h1;
    repeat (2) @(posedge pa_clk);
    `CHK("port_a_bus", 36'h6_3c3c_f0f0, a_wire)
    a_op(1'h0, 1'h1, 1'h0, 1'h1, 36'h0);
    repeat (4) @(posedge pa_clk);
    `CHK("mail2_full_n", 1'h1, mb2_n)
  endtask

  task fill_check();
    int n;
    for (n = 1; n <= DEPTH; n++) begin
      a_op(1'h0, 1'h1, 1'h1, 1'h0, 36'(n - 1));
      if (n == 1 || n == M || n == M + 1) begin
        repeat (5) @(posedge pb_clk);
        `CHK("output_ready", 1'h1, or_rdy)
        `CHK("almost_empty_n", logic'(n > M), aempty_n)
      end
      if (n == DEPTH - M - 1 || n == DEPTH - M || n == DEPTH - 1 || n == DEPTH) begin
        repeat (4) @(posedge pa_clk);
        `CHK("almost_full_n", logic'(DEPTH - n > M), afull_n)
        `CHK("input_ready", logic'(n < DEPTH), in_rdy)
      end
    end
    a_op(1'h0, 1'h1, 1'h1, 1'h0, 36'hf_ffff_ffff);
  endtask

  task drain_check();
    int n;
    @(posedge pb_clk);
    #6;
    for (n = 0; n < DEPTH; n++) b_read(1'h0, 36'(n));
    repeat (5) @(posedge pb_clk);
    `CHK("output_ready", 1'h0, or_rdy)
  endtask

  task retransmit_check();
    a_op(1'h0, 1'h1, 1'h1, 1'h0, 36'h5_0000_00aa);
    a_op(1'h0, 1'h1, 1'h1, 1'h0, 36'h5_0000_00bb);
    repeat (5) @(posedge pb_clk);
    #6 mark_mode = 1'h1;
    b_read(1'h0, 36'h5_0000_00aa);
    @(posedge pb_clk);
    #6 rewind_pin = 1'h1;
    @(posedge pb_clk);
    #6 rewind_pin = 1'h0;
    b_read(1'h0, 36'h5_0000_00aa);
    b_read(1'h0, 36'h5_0000_00bb);
    @(posedge pb_clk);
    #6 mark_mode = 1'h0;
    repeat (5) @(posedge pb_clk);
    `CHK("output_ready", 1'h0, or_rdy)
  endtask

  ////////////////////////////////////////////////////////////////
  task finish_test();
    $display("%0d mismatches in %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    reset_check();
    refuse_check();
    mail_check();
    fill_check();
    drain_check();
    retransmit_check();
    finish_test();
  end
endmodule
